// [verilog/cfgset_regs.svh]
// constants for the configuration set manager: selectors, profiles, word layout
`ifndef CFGSET_REGS_SVH
`define CFGSET_REGS_SVH

// user set selector and startup selector codes
`define CFG_SEL_DEFAULT 2'h0
`define CFG_SEL_USER1 2'h1
`define CFG_SEL_USER2 2'h2
`define CFG_SEL_USER3 2'h3

// factory profile codes for the default set selector
`define CFG_PROF_STANDARD 2'h0
`define CFG_PROF_BOOSTED 2'h1
`define CFG_PROF_SELF_ADJUST 2'h2
`define CFG_PROF_COLOR 2'h3

// word positions inside a configuration set
`define CFG_IDX_GAIN 3'h0
`define CFG_IDX_GAIN_AUTO 3'h1
`define CFG_IDX_EXP_AUTO 3'h2
`define CFG_IDX_EXPOSURE 3'h3
`define CFG_IDX_WHITE_BAL 3'h4
`define CFG_IDX_GAIN_AUTO_MAX 3'h5

// field values; gain is in tenths of a dB above the sensor minimum
`define CFG_GAIN_LOW 16'h0000
`define CFG_GAIN_6DB 16'h003c
`define CFG_GAIN_MAX 16'h00f0
`define CFG_AUTO_OFF 16'h0000
`define CFG_AUTO_CONTINUOUS 16'h0002
`define CFG_EXPOSURE_DEF 16'h0100
`define CFG_WB_NEUTRAL 16'h0000
`define CFG_WB_DAYLIGHT 16'h0001
`define CFG_WORD_ZERO 16'h0000

`endif

// [verilog/cfgset_pkg.sv]
// types shared by the configuration set manager
package cfgset_pkg;
  typedef logic [1:0] set_sel_t;
  typedef logic [1:0] profile_t;
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_SAVE, ST_LOAD} seq_state_t;
endpackage

// [verilog/cfgset_nv_store.sv]
// non-volatile store: three user slots, default profile choice, startup choice
`timescale 1ns/1ps
`default_nettype none
`include "cfgset_regs.svh"
module cfgset_nv_store #(
  parameter int WORDS = 8,
  parameter int W = 16,
  parameter int IW = 3
) (
  input wire logic i_clk,
  input wire logic i_wr_en,
  input wire cfgset_pkg::set_sel_t i_wr_slot,
  input wire logic [IW-1:0] i_wr_idx,
  input wire logic [W-1:0] i_wr_data,
  input wire cfgset_pkg::set_sel_t i_rd_slot,
  input wire logic [IW-1:0] i_rd_idx,
  output logic [W-1:0] o_rd_data,
  input wire logic i_def_we,
  input wire cfgset_pkg::profile_t i_def_sel,
  output cfgset_pkg::profile_t o_def_sel,
  input wire logic i_start_we,
  input wire cfgset_pkg::set_sel_t i_start_sel,
  output cfgset_pkg::set_sel_t o_start_sel
);
  // nothing here sees the reset: contents model the persistent array
  logic [W-1:0] slot_mem [0:3*WORDS-1];
  cfgset_pkg::profile_t def_reg = `CFG_PROF_STANDARD;
  cfgset_pkg::set_sel_t start_reg = `CFG_SEL_DEFAULT;

  function automatic int slot_addr(input cfgset_pkg::set_sel_t slot, input logic [IW-1:0] idx);
    slot_addr = (int'(slot) - 1) * WORDS + int'(idx);
  endfunction

  initial
  begin
    for (int i = 0; i < 3 * WORDS; i++)
    begin
      slot_mem[i] = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_wr_en && i_wr_slot != `CFG_SEL_DEFAULT)
    begin
      slot_mem[slot_addr(i_wr_slot, i_wr_idx)] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_def_we)
    begin
      def_reg <= i_def_sel;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_start_we)
    begin
      start_reg <= i_start_sel;
    end
  end

  always_comb
  begin
    if (i_rd_slot == `CFG_SEL_DEFAULT)
    begin
      o_rd_data = '0;
    end
    else
    begin
      o_rd_data = slot_mem[slot_addr(i_rd_slot, i_rd_idx)];
    end
  end

  assign o_def_sel = def_reg;
  assign o_start_sel = start_reg;
endmodule
`default_nettype wire

// [verilog/cfgset_manager.sv]
// configuration set manager: active set, save/load sequencer, startup load
// What this block does
// - active set is volatile and rebuilt after every reset
// - host parameter writes change only the active set, which drives the outputs
// - four factory profiles are constants that no host operation can overwrite
// - standard profile: low gain, all automatic functions off
// - boosted gain profile: standard but gain plus 6 dB
// - self adjust profile: auto gain and exposure continuous, gain kept minimal
// - host picks any factory profile as default; choice survives reset
// - delivered with the standard profile as default
// - three persistent user slots numbered 1 to 3
// - save copies the active set into the selected user slot
// - lookup table contents are never saved and clear on reset
// - load overwrites the active set from a user slot or the default set
// - after reset the startup set is loaded automatically
`timescale 1ns/1ps
`default_nettype none
`include "cfgset_regs.svh"
module cfgset_manager #(
  parameter int WORDS = 8,
  parameter int W = 16,
  parameter int LUT_DEPTH = 16
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_PARAM_WE,
  input wire logic [2:0] i_PARAM_ADDR,
  input wire logic [W-1:0] i_PARAM_WDATA,
  output logic [W-1:0] o_PARAM_RDATA,
  input wire logic i_LUT_WE,
  input wire logic [3:0] i_LUT_ADDR,
  input wire logic [W-1:0] i_LUT_WDATA,
  output logic [W-1:0] o_LUT_RDATA,
  input wire cfgset_pkg::set_sel_t i_USER_SET_SEL,
  input wire logic i_SAVE,
  input wire logic i_LOAD,
  input wire logic i_DEFAULT_SEL_WE,
  input wire cfgset_pkg::profile_t i_DEFAULT_SEL,
  input wire logic i_STARTUP_SEL_WE,
  input wire cfgset_pkg::set_sel_t i_STARTUP_SEL,
  input wire logic i_ACQ_ACTIVE,
  input wire logic i_ACQ_PENDING,
  output logic o_BUSY,
  output logic o_READY,
  output logic o_DONE,
  output logic o_REFUSED,
  output cfgset_pkg::profile_t o_DEFAULT_SEL,
  output cfgset_pkg::set_sel_t o_STARTUP_SEL,
  output logic [W-1:0] o_GAIN,
  output logic [W-1:0] o_GAIN_AUTO,
  output logic [W-1:0] o_EXPOSURE_AUTO,
  output logic [W-1:0] o_EXPOSURE,
  output logic [W-1:0] o_WHITE_BAL,
  output logic [W-1:0] o_GAIN_AUTO_MAX
);
  localparam int IW = 3;

  cfgset_pkg::seq_state_t state_reg;
  logic [IW-1:0] cnt_reg;
  cfgset_pkg::set_sel_t cmd_sel_reg;
  logic [W-1:0] active_reg [0:WORDS-1];
  logic [W-1:0] lut_reg [0:LUT_DEPTH-1];
  logic done_reg;
  logic refused_reg;
  logic [W-1:0] rdata_reg;
  logic [W-1:0] lut_rdata_reg;

  logic idle;
  logic acq_busy;
  logic save_ok;
  logic load_ok;
  logic def_ok;
  logic start_ok;
  logic refuse_next;
  logic last_word;
  cfgset_pkg::set_sel_t src_sel;
  cfgset_pkg::profile_t def_sel;
  logic [W-1:0] nv_word;
  logic [W-1:0] src_word;

  // factory profiles are fixed logic, so no write path can reach them
  function automatic logic [W-1:0] factory_word(input cfgset_pkg::profile_t prof,
                                                input logic [IW-1:0] idx);
    logic boosted;
    logic adjust;
    boosted = (prof == `CFG_PROF_BOOSTED);
    adjust = (prof == `CFG_PROF_SELF_ADJUST);
    case (idx)
      `CFG_IDX_GAIN: factory_word = boosted ? `CFG_GAIN_6DB : `CFG_GAIN_LOW;
      `CFG_IDX_GAIN_AUTO: factory_word = adjust ? `CFG_AUTO_CONTINUOUS : `CFG_AUTO_OFF;
      `CFG_IDX_EXP_AUTO: factory_word = adjust ? `CFG_AUTO_CONTINUOUS : `CFG_AUTO_OFF;
      `CFG_IDX_EXPOSURE: factory_word = `CFG_EXPOSURE_DEF;
      `CFG_IDX_WHITE_BAL:
        factory_word = (prof == `CFG_PROF_COLOR) ? `CFG_WB_DAYLIGHT : `CFG_WB_NEUTRAL;
      `CFG_IDX_GAIN_AUTO_MAX: factory_word = adjust ? `CFG_GAIN_LOW : `CFG_GAIN_MAX;
      default: factory_word = `CFG_WORD_ZERO;
    endcase
  endfunction

  assign idle = (state_reg == cfgset_pkg::ST_IDLE);
  assign acq_busy = i_ACQ_ACTIVE | i_ACQ_PENDING;
  // save wins if both commands arrive together
  assign save_ok = idle && i_SAVE && (i_USER_SET_SEL != `CFG_SEL_DEFAULT);
  assign load_ok = idle && i_LOAD && !i_SAVE && !acq_busy;
  assign def_ok = idle && i_DEFAULT_SEL_WE && !acq_busy;
  assign start_ok = idle && i_STARTUP_SEL_WE;
  assign refuse_next = (i_SAVE && !save_ok) || (i_LOAD && !i_SAVE && !load_ok)
                       || (i_DEFAULT_SEL_WE && !def_ok);
  assign last_word = (cnt_reg == IW'(WORDS - 1));
  assign src_sel = (state_reg == cfgset_pkg::ST_BOOT) ? o_STARTUP_SEL : cmd_sel_reg;

  cfgset_nv_store #(
    .WORDS(WORDS),
    .W(W),
    .IW(IW)
  ) u_nv (
    .i_clk(I_CLK),
    .i_wr_en(state_reg == cfgset_pkg::ST_SAVE),
    .i_wr_slot(cmd_sel_reg),
    .i_wr_idx(cnt_reg),
    .i_wr_data(active_reg[cnt_reg]),
    .i_rd_slot(src_sel),
    .i_rd_idx(cnt_reg),
    .o_rd_data(nv_word),
    .i_def_we(def_ok),
    .i_def_sel(i_DEFAULT_SEL),
    .o_def_sel(def_sel),
    .i_start_we(start_ok),
    .i_start_sel(i_STARTUP_SEL),
    .o_start_sel(o_STARTUP_SEL)
  );

  assign src_word = (src_sel == `CFG_SEL_DEFAULT) ? factory_word(def_sel, cnt_reg) : nv_word;

  // sequencer: reset always restarts with the startup load
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_reg <= cfgset_pkg::ST_BOOT;
    end
    else
    begin
      case (state_reg)
        cfgset_pkg::ST_BOOT:
          state_reg <= last_word ? cfgset_pkg::ST_IDLE : cfgset_pkg::ST_BOOT;
        cfgset_pkg::ST_IDLE:
        begin
          if (save_ok)
          begin
            state_reg <= cfgset_pkg::ST_SAVE;
          end
          else if (load_ok)
          begin
            state_reg <= cfgset_pkg::ST_LOAD;
          end
        end
        cfgset_pkg::ST_SAVE:
          state_reg <= last_word ? cfgset_pkg::ST_IDLE : cfgset_pkg::ST_SAVE;
        cfgset_pkg::ST_LOAD:
          state_reg <= last_word ? cfgset_pkg::ST_IDLE : cfgset_pkg::ST_LOAD;
        default:
          state_reg <= cfgset_pkg::ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST || idle)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + IW'(1);
    end
  end

  // selector is latched so a change mid-copy cannot split the set
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cmd_sel_reg <= `CFG_SEL_DEFAULT;
    end
    else if (save_ok || load_ok)
    begin
      cmd_sel_reg <= i_USER_SET_SEL;
    end
  end

  // active set: the sequencer owns it while copying, the host otherwise
  always_ff @(posedge I_CLK)
  begin
    if (state_reg == cfgset_pkg::ST_BOOT || state_reg == cfgset_pkg::ST_LOAD)
    begin
      active_reg[cnt_reg] <= src_word;
    end
    else if (idle && i_PARAM_WE && (int'(i_PARAM_ADDR) < WORDS))
    begin
      active_reg[i_PARAM_ADDR] <= i_PARAM_WDATA;
    end
  end

  // lookup table sits outside every set and is wiped by reset
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < LUT_DEPTH; i++)
      begin
        lut_reg[i] <= '0;
      end
    end
    else if (o_READY && i_LUT_WE)
    begin
      lut_reg[i_LUT_ADDR] <= i_LUT_WDATA;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      done_reg <= last_word && (state_reg == cfgset_pkg::ST_SAVE
                                || state_reg == cfgset_pkg::ST_LOAD);
      refused_reg <= refuse_next;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rdata_reg <= '0;
      lut_rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= (int'(i_PARAM_ADDR) < WORDS) ? active_reg[i_PARAM_ADDR] : '0;
      lut_rdata_reg <= lut_reg[i_LUT_ADDR];
    end
  end

  assign o_PARAM_RDATA = rdata_reg;
  assign o_LUT_RDATA = lut_rdata_reg;
  assign o_BUSY = !idle;
  assign o_READY = (state_reg != cfgset_pkg::ST_BOOT);
  assign o_DONE = done_reg;
  assign o_REFUSED = refused_reg;
  assign o_DEFAULT_SEL = def_sel;
  assign o_GAIN = active_reg[`CFG_IDX_GAIN];
  assign o_GAIN_AUTO = active_reg[`CFG_IDX_GAIN_AUTO];
  assign o_EXPOSURE_AUTO = active_reg[`CFG_IDX_EXP_AUTO];
  assign o_EXPOSURE = active_reg[`CFG_IDX_EXPOSURE];
  assign o_WHITE_BAL = active_reg[`CFG_IDX_WHITE_BAL];
  assign o_GAIN_AUTO_MAX = active_reg[`CFG_IDX_GAIN_AUTO_MAX];

  property p_save_runs;
    @(posedge I_CLK) disable iff (I_RST)
    save_ok |=> o_BUSY [*8] ##1 (o_DONE && !o_BUSY);
  endproperty
  a_save_runs: assert property (p_save_runs) else $error("save did not finish in 8 cycles");

  property p_load_refused;
    @(posedge I_CLK) disable iff (I_RST)
    (idle && i_LOAD && !i_SAVE && acq_busy) |=> (o_REFUSED && !o_BUSY);
  endproperty
  a_load_refused: assert property (p_load_refused) else $error("load taken during acquisition");

  property p_def_hold;
    @(posedge I_CLK) disable iff (I_RST)
    (i_DEFAULT_SEL_WE && acq_busy) |=> $stable(o_DEFAULT_SEL);
  endproperty
  a_def_hold: assert property (p_def_hold) else $error("default changed during acquisition");

  property p_def_take;
    @(posedge I_CLK) disable iff (I_RST)
    def_ok |=> (o_DEFAULT_SEL == $past(i_DEFAULT_SEL));
  endproperty
  a_def_take: assert property (p_def_take) else $error("default choice not stored");

  property p_save_default;
    @(posedge I_CLK) disable iff (I_RST)
    (idle && i_SAVE && i_USER_SET_SEL == `CFG_SEL_DEFAULT) |=> (o_REFUSED && !o_BUSY);
  endproperty
  a_save_default: assert property (p_save_default) else $error("save to default accepted");

  property p_boot;
    @(posedge I_CLK)
    $fell(I_RST) |-> !o_READY [*8] ##1 o_READY;
  endproperty
  a_boot: assert property (p_boot) else $error("startup load length wrong");

  property p_host_write;
    @(posedge I_CLK) disable iff (I_RST)
    (idle && i_PARAM_WE && i_PARAM_ADDR == `CFG_IDX_GAIN) |=> (o_GAIN == $past(i_PARAM_WDATA));
  endproperty
  a_host_write: assert property (p_host_write) else $error("gain write lost");

  property p_start_take;
    @(posedge I_CLK) disable iff (I_RST)
    start_ok |=> (o_STARTUP_SEL == $past(i_STARTUP_SEL));
  endproperty
  a_start_take: assert property (p_start_take) else $error("startup choice not stored");

  property p_busy_refuse;
    @(posedge I_CLK) disable iff (I_RST)
    (o_BUSY && o_READY && (i_LOAD || i_SAVE)) |=> o_REFUSED;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("command during copy not refused");
endmodule
`default_nettype wire

// [sim/cfgset_host_model.sv]
// host side model: parameter, lookup table, command and selector traffic
`timescale 1ns/1ps
`default_nettype none
module cfgset_host_model (
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic i_refused,
  input wire logic [15:0] i_rdata,
  input wire logic [15:0] i_lut_rdata,
  output logic o_we,
  output logic [2:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_lut_we,
  output logic [3:0] o_lut_addr,
  output logic [15:0] o_lut_wdata,
  output cfgset_pkg::set_sel_t o_sel,
  output logic o_save,
  output logic o_load,
  output logic o_def_we,
  output cfgset_pkg::profile_t o_def,
  output logic o_start_we,
  output cfgset_pkg::set_sel_t o_start,
  output logic o_acq_active,
  output logic o_acq_pending
);
  initial
  begin
    {o_we, o_addr, o_wdata, o_lut_we, o_lut_addr, o_lut_wdata} = '0;
    {o_sel, o_save, o_load, o_def_we, o_def, o_start_we, o_start} = '0;
    {o_acq_active, o_acq_pending} = 2'h0;
  end

  task automatic wr(input logic lut, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_we <= ~lut;
    o_lut_we <= lut;
    o_addr <= a[2:0];
    o_lut_addr <= a;
    o_wdata <= d;
    o_lut_wdata <= d;
    @(posedge i_clk);
    o_we <= 1'b0;
    o_lut_we <= 1'b0;
  endtask

  task automatic rd(input logic lut, input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a[2:0];
    o_lut_addr <= a;
    @(posedge i_clk);
    #1;
    d = lut ? i_lut_rdata : i_rdata;
  endtask

  // bs raises a save in the cycle after the first command, while still busy
  task automatic cmd(input logic s, input logic l, input logic [1:0] sel, input logic bs,
                     output logic done, output logic refd);
    done = 1'b0;
    refd = 1'b0;
    @(posedge i_clk);
    o_sel <= sel;
    o_save <= s;
    o_load <= l;
    @(posedge i_clk);
    o_load <= 1'b0;
    o_save <= bs;
    for (int n = 0; n < 13; n++)
    begin
      #1;
      done = done | (i_done === 1'b1);
      refd = refd | (i_refused === 1'b1);
      @(posedge i_clk);
      o_save <= 1'b0;
    end
  endtask

  task automatic sel_wr(input logic def, input logic [1:0] v, output logic refd);
    refd = 1'b0;
    @(posedge i_clk);
    o_def_we <= def;
    o_start_we <= ~def;
    o_def <= v;
    o_start <= v;
    @(posedge i_clk);
    o_def_we <= 1'b0;
    o_start_we <= 1'b0;
    repeat (3)
    begin
      #1;
      refd = refd | (i_refused === 1'b1);
      @(posedge i_clk);
    end
  endtask

  // idle outside the refusal tests, which break this on purpose
  task automatic acq(input logic a, input logic p);
    @(posedge i_clk);
    o_acq_active <= a;
    o_acq_pending <= p;
  endtask
endmodule
`default_nettype wire

// [sim/cfgset_manager_tb_top.sv]
// self-checking bench for the configuration set manager
`timescale 1ns/1ps
`default_nettype none
`include "cfgset_regs.svh"
module cfgset_manager_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we, lut_we, save, load, def_we, start_we, acq_a, acq_p, busy, ready, done, refd;
  logic [2:0] addr;
  logic [3:0] lut_addr;
  logic [15:0] wdata, rdata, lut_wdata, lut_rdata;
  logic [15:0] outs [6];
  cfgset_pkg::set_sel_t sel, start, start_o;
  cfgset_pkg::profile_t def, def_o;
  int act [8];
  int slot [4][8];
  int defp = 0;
  int start_m = 0;
  int errors = 0;
  int num_checks = 0;
  int seed = 32'hb209;

  always #2.5 clk = ~clk;

  cfgset_manager i_dut (.I_CLK(clk), .I_RST(rst), .i_PARAM_WE(we), .i_PARAM_ADDR(addr),
    .i_PARAM_WDATA(wdata), .o_PARAM_RDATA(rdata), .i_LUT_WE(lut_we), .i_LUT_ADDR(lut_addr),
    .i_LUT_WDATA(lut_wdata), .o_LUT_RDATA(lut_rdata), .i_USER_SET_SEL(sel), .i_SAVE(save),
    .i_LOAD(load), .i_DEFAULT_SEL_WE(def_we), .i_DEFAULT_SEL(def),
    .i_STARTUP_SEL_WE(start_we), .i_STARTUP_SEL(start), .i_ACQ_ACTIVE(acq_a),
    .i_ACQ_PENDING(acq_p), .o_BUSY(busy), .o_READY(ready), .o_DONE(done),
    .o_REFUSED(refd), .o_DEFAULT_SEL(def_o), .o_STARTUP_SEL(start_o), .o_GAIN(outs[0]),
    .o_GAIN_AUTO(outs[1]), .o_EXPOSURE_AUTO(outs[2]), .o_EXPOSURE(outs[3]),
    .o_WHITE_BAL(outs[4]), .o_GAIN_AUTO_MAX(outs[5]));

  cfgset_host_model i_host (.i_clk(clk), .i_done(done), .i_refused(refd), .i_rdata(rdata),
    .i_lut_rdata(lut_rdata), .o_we(we), .o_addr(addr), .o_wdata(wdata), .o_lut_we(lut_we),
    .o_lut_addr(lut_addr), .o_lut_wdata(lut_wdata), .o_sel(sel), .o_save(save),
    .o_load(load), .o_def_we(def_we), .o_def(def), .o_start_we(start_we), .o_start(start),
    .o_acq_active(acq_a), .o_acq_pending(acq_p));

  task automatic check(input string what, input logic [15:0] seen, input int exp);
    if (exp >= 0)
    begin
      num_checks++;
      if (seen !== exp[15:0])
      begin
        errors++;
        $display("unexpected %s: expected %h seen %h", what, exp[15:0], seen);
      end
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // -1 marks words that a profile leaves open
  task automatic load_prof(input int p);
    foreach (act[k]) act[k] = -1;
    if (p < 2)
    begin
      act[`CFG_IDX_GAIN] = (p == 1) ? `CFG_GAIN_6DB : `CFG_GAIN_LOW;
      act[`CFG_IDX_GAIN_AUTO] = `CFG_AUTO_OFF;
      act[`CFG_IDX_EXP_AUTO] = `CFG_AUTO_OFF;
    end
    if (p == 2)
    begin
      act[`CFG_IDX_GAIN_AUTO] = `CFG_AUTO_CONTINUOUS;
      act[`CFG_IDX_EXP_AUTO] = `CFG_AUTO_CONTINUOUS;
      act[`CFG_IDX_GAIN_AUTO_MAX] = `CFG_GAIN_LOW;
    end
    if (p == 3)
      act[`CFG_IDX_WHITE_BAL] = `CFG_WB_DAYLIGHT;
  endtask

  task automatic chk_outs();
    // let the edge that launched the outputs settle first
    #1;
    for (int k = 0; k < 6; k++)
      check("active word", outs[k], act[k]);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      #1;
      if (ready === 1'b1)
        break;
    end
    check("ready", {15'h0, ready}, 1);
    check("busy after boot", {15'h0, busy}, 0);
    if (start_m == 0)
      load_prof(defp);
    else
      act = slot[start_m];
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial
  begin
    logic dn, rf;
    logic [15:0] d;
    do_reset();
    chk_outs();
    check("default sel", {14'h0, def_o}, 0);
    $display("test boot done");
    for (int k = 0; k < 6; k++)
    begin
      act[k] = $random(seed) & 'hffff;
      i_host.wr(1'b0, k[3:0], act[k][15:0]);
    end
    chk_outs();
    for (int k = 0; k < 6; k++)
    begin
      i_host.rd(1'b0, k[3:0], d);
      check("param read", d, act[k]);
    end
    i_host.wr(1'b1, 4'h9, 16'ha5c3);
    $display("test params done");
    for (int s = 1; s < 4; s++)
    begin
      act[0] = $random(seed) & 'hffff;
      i_host.wr(1'b0, 4'h0, act[0][15:0]);
      i_host.cmd(1'b1, 1'b0, s[1:0], 1'b0, dn, rf);
      check("save done", {15'h0, dn}, 1);
      slot[s] = act;
    end
    i_host.cmd(1'b1, 1'b0, 2'h0, 1'b0, dn, rf);
    check("save to default refused", {15'h0, rf}, 1);
    for (int s = 3; s > 0; s--)
    begin
      i_host.wr(1'b0, 4'h0, 16'h7777);
      i_host.cmd(1'b0, 1'b1, s[1:0], 1'b0, dn, rf);
      check("load done", {15'h0, dn}, 1);
      act = slot[s];
      chk_outs();
    end
    i_host.rd(1'b1, 4'h9, d);
    check("lut kept", d, 'ha5c3);
    $display("test save load done");
    i_host.acq(1'b1, 1'b0);
    i_host.cmd(1'b0, 1'b1, 2'h2, 1'b0, dn, rf);
    check("load in acq refused", {15'h0, rf}, 1);
    check("load in acq done", {15'h0, dn}, 0);
    i_host.acq(1'b0, 1'b1);
    i_host.sel_wr(1'b1, 2'h2, rf);
    check("default in acq refused", {15'h0, rf}, 1);
    check("default kept", {14'h0, def_o}, 0);
    i_host.acq(1'b0, 1'b0);
    chk_outs();
    i_host.cmd(1'b0, 1'b1, 2'h2, 1'b1, dn, rf);
    check("busy save refused", {15'h0, rf}, 1);
    check("first load done", {15'h0, dn}, 1);
    act = slot[2];
    chk_outs();
    $display("test refusals done");
    for (int p = 0; p < 4; p++)
    begin
      i_host.sel_wr(1'b1, p[1:0], rf);
      check("default write", {14'h0, def_o}, p);
      i_host.cmd(1'b0, 1'b1, 2'h0, 1'b0, dn, rf);
      defp = p;
      load_prof(p);
      chk_outs();
    end
    i_host.sel_wr(1'b1, 2'h1, rf);
    defp = 1;
    $display("test profiles done");
    i_host.sel_wr(1'b0, 2'h2, rf);
    start_m = 2;
    do_reset();
    check("startup kept", {14'h0, start_o}, 2);
    check("default kept", {14'h0, def_o}, 1);
    chk_outs();
    i_host.rd(1'b1, 4'h9, d);
    check("lut cleared", d, 0);
    i_host.sel_wr(1'b0, 2'h0, rf);
    start_m = 0;
    do_reset();
    chk_outs();
    $display("test startup done");
    wrap_up();
  end
endmodule
`default_nettype wire
